// *** rtl/fct_consts.vh ***
`ifndef FCT_CONSTS_VH
`define FCT_CONSTS_VH
// ****************
// modes of the classic timers
// ****************
`define FCT_MODE_13BIT 2'h0
`define FCT_MODE_16BIT 2'h1
`define FCT_MODE_RELOAD8 2'h2
`define FCT_MODE_SPLIT8 2'h3
// ****************
// prescale field codes
// ****************
`define FCT_SCA_DIV12 2'h0
`define FCT_SCA_DIV4 2'h1
`define FCT_SCA_DIV48 2'h2
`define FCT_SCA_EXT8 2'h3
// ****************
// divide ratios
// ****************
`define FCT_DIV_12 12
`define FCT_DIV_4 4
`define FCT_DIV_48 48
`define FCT_DIV_EXT 8
// ****************
// reset values
// ****************
`define FCT_RST_BYTE 8'h00
`endif

// *** rtl/fct_reload_timer.v ***
`timescale 1ns/1ps
`default_nettype none
`include "fct_consts.vh"
// 16-bit auto-reload timer, optionally split into two 8-bit auto-reload timers
module fct_reload_timer (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // control
  input wire run_lo,
  input wire run_hi,
  input wire split,
  input wire tick_lo,
  input wire tick_hi,
  input wire [7:0] reload_lo,
  input wire [7:0] reload_hi,
  // state
  output reg [7:0] count_lo_q,
  output reg [7:0] count_hi_q,
  output reg ovf_lo_q,
  output reg ovf_hi_q
);
  wire inc_lo = run_lo && tick_lo;
  wire inc_hi = split ? (run_hi && tick_hi) : (inc_lo && count_lo_q == 8'hFF);
  always @(posedge clk) begin
    if (sys_rst) begin
      count_lo_q <= `FCT_RST_BYTE;
      count_hi_q <= `FCT_RST_BYTE;
      ovf_lo_q <= 1'b0;
      ovf_hi_q <= 1'b0;
    end else begin
      ovf_lo_q <= 1'b0;
      ovf_hi_q <= 1'b0;
      if (split) begin // [RULE3]
        if (inc_lo) begin
          count_lo_q <= (count_lo_q == 8'hFF) ? reload_lo : count_lo_q + 8'h01;
          ovf_lo_q <= (count_lo_q == 8'hFF);
        end
        if (inc_hi) begin
          count_hi_q <= (count_hi_q == 8'hFF) ? reload_hi : count_hi_q + 8'h01;
          ovf_hi_q <= (count_hi_q == 8'hFF);
        end
      end else if (inc_lo) begin // [RULE3]
        if (count_lo_q == 8'hFF && count_hi_q == 8'hFF) begin
          count_lo_q <= reload_lo;
          count_hi_q <= reload_hi;
          ovf_hi_q <= 1'b1;
        end else begin
          count_lo_q <= count_lo_q + 8'h01;
          if (inc_hi) begin
            count_hi_q <= count_hi_q + 8'h01;
          end
        end
      end
    end
  end
endmodule // fct_reload_timer
`default_nettype wire

// *** rtl/fct_timer_set.v ***
// Functional notes
// RULE1: four timers are built, two classic 16-bit counter/timers and two 16-bit auto-reload timers.
// RULE2: classic timers do 13-bit, 16-bit and 8-bit reload modes, and only timer zero splits into two 8-bit.
// RULE3: each auto-reload timer runs as one 16-bit reload timer or two 8-bit reload timers.
// RULE4: classic timer clock comes from five sources chosen by select bits and the prescale field.
// RULE5: each classic timer runs from the prescaled clock or straight from the core clock.
// RULE6: auto-reload timers tick from the core clock, core clock over 12, or external clock over 8.
// RULE7: in counter mode the count goes up once per falling edge on the count pin.
// RULE8: counter mode handles events up to a quarter of the core clock rate.
// RULE9: the event source holds each pin level at least two core clock cycles.
// RULE10: timers give periodic overflow requests, measure intervals and count events.
// RULE11: count pins are synchronised and a falling edge between two samples makes a one-cycle pulse.
// RULE12: prescale 00 divides by 12, 01 by 4, 10 by 48, 11 gives external clock over 8.
// RULE13: in 13-bit mode the wrap from all ones to zero sets the overflow flag and requests an interrupt.
// RULE14: a classic timer counts only when run is set and gate is clear or the interrupt input is active.
// RULE15: in 8-bit reload mode the low byte wraps, sets the flag and reloads from the unchanged high byte.
`timescale 1ns/1ps
`default_nettype none
`include "fct_consts.vh"
module fct_timer_set (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // external sources
  input wire ext_osc_clk,
  input wire count_input_pin_zero,
  input wire count_input_pin_one,
  input wire external_interrupt_zero_input,
  input wire external_interrupt_one_input,
  // shared clock config
  input wire [1:0] prescale_select_field,
  input wire timer0_core_clock_select,
  input wire timer1_core_clock_select,
  // timer zero config
  input wire [1:0] timer0_mode,
  input wire timer0_counter_mode,
  input wire timer0_run_bit,
  input wire timer0_gate_bit,
  input wire timer0_int_polarity,
  // timer one config
  input wire [1:0] timer1_mode,
  input wire timer1_counter_mode,
  input wire timer1_run_bit,
  input wire timer1_gate_bit,
  input wire timer1_int_polarity,
  // software writes to classic count bytes
  input wire timer0_low_byte_we,
  input wire timer0_high_byte_we,
  input wire timer1_low_byte_we,
  input wire timer1_high_byte_we,
  input wire [7:0] wr_data,
  // flag clears
  input wire timer0_flag_clr,
  input wire timer1_flag_clr,
  input wire [3:0] reload_flag_clr,
  // auto-reload timers: per timer index 0/1
  input wire [1:0] reload_run,
  input wire [1:0] reload_split,
  input wire [3:0] reload_clk_sel,
  input wire [15:0] reload_value_a,
  input wire [15:0] reload_value_b,
  // classic timer state
  output reg [7:0] timer0_low_byte,
  output reg [7:0] timer0_high_byte,
  output reg [7:0] timer1_low_byte,
  output reg [7:0] timer1_high_byte,
  output reg timer0_overflow_flag,
  output reg timer1_overflow_flag,
  // auto-reload timer state
  output reg [15:0] reload_count_a,
  output reg [15:0] reload_count_b,
  output reg [3:0] reload_flags
);
  // ****************
  // input synchronisers and edge pulses
  // ****************
  reg [1:0] pin0_s_q, pin1_s_q, ext_s_q;
  reg pin0_old_q, pin1_old_q, ext_old_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      pin0_s_q <= 2'h3;
      pin1_s_q <= 2'h3;
      ext_s_q <= 2'h0;
      pin0_old_q <= 1'b1;
      pin1_old_q <= 1'b1;
      ext_old_q <= 1'b0;
    end else begin
      // first stage read only by the second; rates beyond a quarter are aliased
      pin0_s_q <= {pin0_s_q[0], count_input_pin_zero}; // [RULE11] [RULE8]
      pin1_s_q <= {pin1_s_q[0], count_input_pin_one}; // [RULE11]
      ext_s_q <= {ext_s_q[0], ext_osc_clk};
      pin0_old_q <= pin0_s_q[1];
      pin1_old_q <= pin1_s_q[1];
      ext_old_q <= ext_s_q[1];
    end
  end
  // relies on the source holding each level two cycles [RULE9]
  wire fall0 = pin0_old_q && !pin0_s_q[1]; // [RULE11] [RULE7]
  wire fall1 = pin1_old_q && !pin1_s_q[1]; // [RULE11] [RULE7]
  wire ext_rise = !ext_old_q && ext_s_q[1];

  // ****************
  // prescaler
  // ****************
  reg [5:0] div12_q, div4_q, div48_q;
  reg [2:0] div8_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      div12_q <= 6'h00;
      div4_q <= 6'h00;
      div48_q <= 6'h00;
      div8_q <= 3'h0;
    end else begin
      div12_q <= (div12_q == 6'd`FCT_DIV_12 - 6'd1) ? 6'h00 : div12_q + 6'h01;
      div4_q <= (div4_q == 6'd`FCT_DIV_4 - 6'd1) ? 6'h00 : div4_q + 6'h01;
      div48_q <= (div48_q == 6'd`FCT_DIV_48 - 6'd1) ? 6'h00 : div48_q + 6'h01;
      if (ext_rise) begin
        div8_q <= ({1'b0, div8_q} == 4'd`FCT_DIV_EXT - 4'd1) ? 3'h0 : div8_q + 3'h1;
      end
    end
  end
  wire tick12 = (div12_q == 6'h00);
  wire tick4 = (div4_q == 6'h00);
  wire tick48 = (div48_q == 6'h00);
  wire tick_ext8 = ext_rise && (div8_q == 3'h0);
  reg tick_pre;
  always @* begin
    case (prescale_select_field) // [RULE12]
      `FCT_SCA_DIV12: tick_pre = tick12;
      `FCT_SCA_DIV4: tick_pre = tick4;
      `FCT_SCA_DIV48: tick_pre = tick48;
      default: tick_pre = tick_ext8;
    endcase
  end

  // ****************
  // classic timer enables
  // ****************
  wire t0_src = timer0_counter_mode ? fall0 : (timer0_core_clock_select ? 1'b1 : tick_pre); // [RULE4] [RULE5]
  wire t1_src = timer1_counter_mode ? fall1 : (timer1_core_clock_select ? 1'b1 : tick_pre); // [RULE4] [RULE5]
  wire external_interrupt_zero_input_act = (external_interrupt_zero_input == timer0_int_polarity);
  wire int1_act = (external_interrupt_one_input == timer1_int_polarity);
  wire t0_en = timer0_run_bit && (!timer0_gate_bit || external_interrupt_zero_input_act); // [RULE14]
  wire t1_en = timer1_run_bit && (!timer1_gate_bit || int1_act); // [RULE14]
  // split mode: high byte of timer zero runs off timer one's run bit and clock
  wire t0_split = (timer0_mode == `FCT_MODE_SPLIT8);
  wire t0h_en = timer1_run_bit && (timer1_core_clock_select ? 1'b1 : tick_pre);

  // ****************
  // classic timer zero
  // ****************
  wire [12:0] t0_13 = {timer0_high_byte, timer0_low_byte[4:0]};
  wire [15:0] t0_16 = {timer0_high_byte, timer0_low_byte};
  always @(posedge clk) begin
    if (sys_rst) begin
      timer0_low_byte <= `FCT_RST_BYTE;
      timer0_high_byte <= `FCT_RST_BYTE;
      timer0_overflow_flag <= 1'b0;
    end else begin
      if (timer0_flag_clr) timer0_overflow_flag <= 1'b0; // a set further down wins
      if (t0_en && t0_src) begin
        case (timer0_mode) // [RULE2]
          `FCT_MODE_13BIT: begin
            timer0_high_byte <= t0_13[12:5] + {7'h00, &t0_13[4:0]};
            timer0_low_byte <= {timer0_low_byte[7:5], t0_13[4:0] + 5'h01};
            if (&t0_13) timer0_overflow_flag <= 1'b1; // [RULE13] [RULE10]
          end
          `FCT_MODE_16BIT: begin
            {timer0_high_byte, timer0_low_byte} <= t0_16 + 16'h0001;
            if (&t0_16) timer0_overflow_flag <= 1'b1;
          end
          `FCT_MODE_RELOAD8: begin
            if (&timer0_low_byte) begin
              timer0_low_byte <= timer0_high_byte; // [RULE15]
              timer0_overflow_flag <= 1'b1; // [RULE15]
            end else begin
              timer0_low_byte <= timer0_low_byte + 8'h01;
            end
          end
          default: begin
            timer0_low_byte <= timer0_low_byte + 8'h01;
            if (&timer0_low_byte) timer0_overflow_flag <= 1'b1;
          end
        endcase
      end
      if (t0_split && t0h_en) begin
        timer0_high_byte <= timer0_high_byte + 8'h01;
      end
      // software writes take priority over counting
      if (timer0_low_byte_we) timer0_low_byte <= wr_data;
      if (timer0_high_byte_we) timer0_high_byte <= wr_data;
    end
  end

  // ****************
  // classic timer one
  // ****************
  wire [12:0] t1_13 = {timer1_high_byte, timer1_low_byte[4:0]};
  wire [15:0] t1_16 = {timer1_high_byte, timer1_low_byte};
  // timer one's flag belongs to timer zero's high byte in split mode
  wire t0h_ovf = t0_split && t0h_en && (&timer0_high_byte);
  always @(posedge clk) begin
    if (sys_rst) begin
      timer1_low_byte <= `FCT_RST_BYTE;
      timer1_high_byte <= `FCT_RST_BYTE;
      timer1_overflow_flag <= 1'b0;
    end else begin
      if (t0h_ovf) begin
        timer1_overflow_flag <= 1'b1;
      end else if (timer1_flag_clr) begin // a set further down wins
        timer1_overflow_flag <= 1'b0;
      end
      // timer zero's split only takes timer one's flag; timer one's own split mode stops it
      if (t1_en && t1_src && timer1_mode != `FCT_MODE_SPLIT8) begin
        case (timer1_mode) // [RULE2]
          `FCT_MODE_13BIT: begin
            timer1_high_byte <= t1_13[12:5] + {7'h00, &t1_13[4:0]};
            timer1_low_byte <= {timer1_low_byte[7:5], t1_13[4:0] + 5'h01};
            if (&t1_13 && !t0_split) timer1_overflow_flag <= 1'b1; // [RULE13]
          end
          `FCT_MODE_16BIT: begin
            {timer1_high_byte, timer1_low_byte} <= t1_16 + 16'h0001;
            if (&t1_16 && !t0_split) timer1_overflow_flag <= 1'b1;
          end
          default: begin
            if (&timer1_low_byte) begin
              timer1_low_byte <= timer1_high_byte; // [RULE15]
              if (!t0_split) timer1_overflow_flag <= 1'b1;
            end else begin
              timer1_low_byte <= timer1_low_byte + 8'h01;
            end
          end
        endcase
      end
      if (timer1_low_byte_we) timer1_low_byte <= wr_data;
      if (timer1_high_byte_we) timer1_high_byte <= wr_data;
    end
  end

  // ****************
  // auto-reload timers
  // ****************
  wire [15:0] rl_val [0:1];
  wire [15:0] rl_cnt [0:1];
  wire [1:0] ovf_lo, ovf_hi;
  assign rl_val[0] = reload_value_a;
  assign rl_val[1] = reload_value_b;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_rl
      reg tk;
      always @* begin
        case (reload_clk_sel[2*gi+1:2*gi]) // [RULE6]
          2'h0: tk = tick12;
          2'h1: tk = tick_ext8;
          default: tk = 1'b1;
        endcase
      end
      fct_reload_timer u_tmr (
        .clk(clk),
        .sys_rst(sys_rst),
        .run_lo(reload_run[gi]),
        .run_hi(reload_run[gi]),
        .split(reload_split[gi]),
        .tick_lo(tk),
        .tick_hi(tk),
        .reload_lo(rl_val[gi][7:0]),
        .reload_hi(rl_val[gi][15:8]),
        .count_lo_q(rl_cnt[gi][7:0]),
        .count_hi_q(rl_cnt[gi][15:8]),
        .ovf_lo_q(ovf_lo[gi]),
        .ovf_hi_q(ovf_hi[gi])
      ); // [RULE1]
    end
  endgenerate
  integer k;
  always @(posedge clk) begin
    if (sys_rst) begin
      reload_count_a <= 16'h0000;
      reload_count_b <= 16'h0000;
      reload_flags <= 4'h0;
    end else begin
      reload_count_a <= rl_cnt[0];
      reload_count_b <= rl_cnt[1];
      for (k = 0; k < 2; k = k + 1) begin
        // set wins over clear
        reload_flags[2*k] <= ovf_lo[k] | (reload_flags[2*k] & ~reload_flag_clr[2*k]);
        reload_flags[2*k+1] <= ovf_hi[k] | (reload_flags[2*k+1] & ~reload_flag_clr[2*k+1]); // [RULE10]
      end
    end
  end
endmodule // fct_timer_set
`default_nettype wire

// *** bench/fct_event_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module fct_event_src (
  // core clock
  input wire logic clk,
  // event lines
  output logic ext_osc_clk,
  output logic count_input_pin_zero,
  output logic count_input_pin_one
);
  // free-running oscillator, four core periods, phase unrelated
  initial begin
    ext_osc_clk = 1'b0;
    #13;
    forever #80 ext_osc_clk = ~ext_osc_clk;
  end
  // pins idle high as with a pull-up
  initial begin
    count_input_pin_zero = 1'b1;
    count_input_pin_one = 1'b1;
  end
  // two cycles low, two high: fastest legal event rate
  task automatic pulses(input logic sel, input int n);
    repeat (n) begin
      @(negedge clk);
      if (sel) count_input_pin_one = 1'b0;
      else count_input_pin_zero = 1'b0;
      repeat (2) @(negedge clk);
      count_input_pin_zero = 1'b1;
      count_input_pin_one = 1'b1;
      @(negedge clk);
    end
  endtask
endmodule // fct_event_src
`default_nettype wire

// *** bench/fct_timer_set_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fct_consts.vh"
module fct_timer_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // timer zero control
  input wire logic [1:0] timer0_mode,
  input wire logic timer0_counter_mode,
  input wire logic timer0_run_bit,
  input wire logic timer0_gate_bit,
  input wire logic timer0_int_polarity,
  input wire logic external_interrupt_zero_input,
  input wire logic timer0_core_clock_select,
  input wire logic timer0_low_byte_we,
  input wire logic timer0_high_byte_we,
  input wire logic timer0_flag_clr,
  input wire logic [7:0] wr_data,
  // timer zero state
  input wire logic [7:0] timer0_low_byte,
  input wire logic [7:0] timer0_high_byte,
  input wire logic timer0_overflow_flag
);
  logic en0;
  logic tick0;
  assign en0 = timer0_run_bit && (!timer0_gate_bit || external_interrupt_zero_input == timer0_int_polarity);
  assign tick0 = en0 && timer0_core_clock_select && !timer0_counter_mode && !timer0_low_byte_we && !timer0_high_byte_we;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_reset_zero: assert property (disable iff (1'b0) sys_rst |=>
    {timer0_high_byte, timer0_low_byte} == 16'h0000 && !timer0_overflow_flag) else $error("reset left state");
  a_stop_hold: assert property (!en0 && !timer0_low_byte_we |=> $stable(timer0_low_byte))
    else $error("low byte moved while stopped");
  a_tick_step: assert property (tick0 && timer0_mode == `FCT_MODE_16BIT && timer0_low_byte != 8'hFF |=>
    timer0_low_byte == $past(timer0_low_byte) + 8'h01 && $stable(timer0_high_byte)) else $error("bad step");
  a_wrap_full: assert property (tick0 && timer0_mode == `FCT_MODE_16BIT &&
    {timer0_high_byte, timer0_low_byte} == 16'hFFFF |=> {timer0_high_byte, timer0_low_byte} == 16'h0000
    && timer0_overflow_flag) else $error("bad 16-bit wrap");
  a_wrap_short: assert property (tick0 && timer0_mode == `FCT_MODE_13BIT &&
    timer0_high_byte == 8'hFF && timer0_low_byte[4:0] == 5'h1F |=> timer0_high_byte == 8'h00
    && timer0_low_byte[4:0] == 5'h00 && timer0_overflow_flag) else $error("bad 13-bit wrap");
  a_reload_byte: assert property (tick0 && timer0_mode == `FCT_MODE_RELOAD8 && timer0_low_byte == 8'hFF |=>
    timer0_low_byte == $past(timer0_high_byte) && $stable(timer0_high_byte) && timer0_overflow_flag)
    else $error("bad reload");
  a_write_load: assert property (timer0_low_byte_we |=> timer0_low_byte == $past(wr_data))
    else $error("write not loaded");
  a_flag_sticky: assert property (timer0_overflow_flag && !timer0_flag_clr |=> timer0_overflow_flag)
    else $error("flag dropped");
  a_flag_clear: assert property (timer0_flag_clr && !timer0_run_bit |=> !timer0_overflow_flag)
    else $error("flag not cleared");
  c_wrap: cover property (tick0 && {timer0_high_byte, timer0_low_byte} == 16'hFFFF);
  c_reload: cover property (tick0 && timer0_mode == `FCT_MODE_RELOAD8 && timer0_low_byte == 8'hFF);
  c_gated: cover property (timer0_run_bit && !en0);
endmodule // fct_timer_monitor
bind fct_timer_set fct_timer_monitor u_fct_timer_monitor (.*);
`default_nettype wire

// *** bench/test_four_counter_timer_set.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fct_consts.vh"
module test_four_counter_timer_set;
  typedef struct packed {logic [1:0] ps; logic sy; logic [1:0] rs; logic [7:0] e0; logic [7:0] er;} fct_row_t;
  logic clk, ext_osc_clk, count_input_pin_zero, count_input_pin_one, sys_rst = '1;
  logic external_interrupt_zero_input = '0, external_interrupt_one_input = '0, timer0_core_clock_select = '0;
  logic timer1_core_clock_select = '0, timer0_counter_mode = '0, timer0_run_bit = '0, timer0_gate_bit = '0;
  logic timer0_int_polarity = '0, timer1_counter_mode = '0, timer1_run_bit = '0, timer1_gate_bit = '0;
  logic timer1_int_polarity = '0, timer0_low_byte_we = '0, timer0_high_byte_we = '0, timer1_low_byte_we = '0;
  logic timer1_high_byte_we = '0, timer0_flag_clr = '0, timer1_flag_clr = '0;
  logic [1:0] prescale_select_field = '0, timer0_mode = '0, timer1_mode = '0, reload_run = '0, reload_split = '0;
  logic [3:0] reload_flag_clr = '0, reload_clk_sel = '0, reload_flags;
  logic [7:0] wr_data = '0, timer0_low_byte, timer0_high_byte, timer1_low_byte, timer1_high_byte;
  logic [15:0] reload_value_a = '0, reload_value_b = '0, reload_count_a, reload_count_b, a0, a1, ra, rb;
  logic timer0_overflow_flag, timer1_overflow_flag;
  int fail_count, checks, cyc;
  int np[3] = '{5, 3, 2};
  logic [15:0] ne[3] = '{16'h0005, 16'h0005, 16'h0007};
  fct_row_t rows[5] = '{'{2'h0, 1'h0, 2'h0, 8'h08, 8'h08}, '{2'h1, 1'h0, 2'h1, 8'h18, 8'h03},
    '{2'h2, 1'h0, 2'h2, 8'h02, 8'h60}, '{2'h3, 1'h0, 2'h3, 8'h03, 8'h60}, '{2'h0, 1'h1, 2'h2, 8'h60, 8'h60}};
  fct_timer_set u_fct_timer_set (.*);
  fct_event_src u_fct_event_src (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chkf(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic give_verdict;
    $display("checks %0d, fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic load0(input logic [7:0] h, input logic [7:0] l);
    wr_data = h;
    timer0_high_byte_we = 1'b1;
    @(negedge clk);
    timer0_high_byte_we = 1'b0;
    wr_data = l;
    timer0_low_byte_we = 1'b1;
    @(negedge clk);
    timer0_low_byte_we = 1'b0;
  endtask
  task automatic run0(input int n);
    timer0_run_bit = 1'b1;
    repeat (n) @(negedge clk);
    timer0_run_bit = 1'b0;
    @(negedge clk);
  endtask
  // run is short; the ceiling only catches a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    chk({timer0_high_byte, timer0_low_byte}, 16'h0000);
    // ****************
    // clock sources, windows a whole number of tick periods
    // ****************
    timer0_mode = `FCT_MODE_16BIT;
    timer1_mode = `FCT_MODE_16BIT;
    reload_run = 2'h3;
    timer0_run_bit = 1'b1;
    timer1_run_bit = 1'b1;
    foreach (rows[i]) begin
      prescale_select_field = rows[i].ps;
      timer0_core_clock_select = rows[i].sy;
      timer1_core_clock_select = rows[i].sy;
      reload_clk_sel = {2{rows[i].rs}};
      repeat (4) @(negedge clk);
      a0 = {timer0_high_byte, timer0_low_byte};
      a1 = {timer1_high_byte, timer1_low_byte};
      ra = reload_count_a;
      rb = reload_count_b;
      repeat (96) @(negedge clk);
      chk({timer0_high_byte, timer0_low_byte} - a0, {8'h00, rows[i].e0});
      chk({timer1_high_byte, timer1_low_byte} - a1, {8'h00, rows[i].e0});
      chk(reload_count_a - ra, {8'h00, rows[i].er});
      chk(reload_count_b - rb, {8'h00, rows[i].er});
    end
    // ****************
    // pin events, gating
    // ****************
    timer0_run_bit = 1'b0;
    timer0_counter_mode = 1'b1;
    timer0_int_polarity = 1'b1;
    load0(8'h00, 8'h00);
    timer0_run_bit = 1'b1;
    for (int k = 0; k < 3; k++) begin
      timer0_gate_bit = (k > 0);
      external_interrupt_zero_input = (k == 2);
      u_fct_event_src.pulses(1'b0, np[k]);
      repeat (4) @(negedge clk);
      chk({8'h00, timer0_low_byte}, ne[k]);
    end
    // ****************
    // wraps and reload
    // ****************
    timer0_run_bit = 1'b0;
    timer0_counter_mode = 1'b0;
    timer0_gate_bit = 1'b0;
    for (int m = 0; m < 2; m++) begin
      timer0_mode = m[1:0];
      load0(8'hFF, m ? 8'hFF : 8'h1F);
      run0(1);
      chk({timer0_high_byte, timer0_low_byte & (m ? 8'hFF : 8'h1F)}, 16'h0000);
      chkf(timer0_overflow_flag, 1'b1);
      timer0_flag_clr = 1'b1;
      @(negedge clk);
      timer0_flag_clr = 1'b0;
      @(negedge clk);
      chkf(timer0_overflow_flag, 1'b0);
    end
    timer0_mode = `FCT_MODE_RELOAD8;
    load0(8'hF0, 8'hFE);
    run0(3);
    chk({timer0_high_byte, timer0_low_byte}, 16'hF0F1);
    chkf(timer0_overflow_flag, 1'b1);
    // ****************
    // split timer zero, high byte overflow lands in timer one's flag
    // ****************
    timer1_run_bit = 1'b0;
    timer0_mode = `FCT_MODE_SPLIT8;
    timer0_flag_clr = 1'b1;
    timer1_flag_clr = 1'b1;
    load0(8'hFF, 8'hFE);
    timer0_flag_clr = 1'b0;
    timer1_flag_clr = 1'b0;
    chk({14'h0000, timer0_overflow_flag, timer1_overflow_flag}, 16'h0000);
    timer0_run_bit = 1'b1;
    timer1_run_bit = 1'b1;
    repeat (2) @(negedge clk);
    timer0_run_bit = 1'b0;
    timer1_run_bit = 1'b0;
    @(negedge clk);
    chk({timer0_high_byte, timer0_low_byte}, 16'h0100);
    chk({14'h0000, timer0_overflow_flag, timer1_overflow_flag}, 16'h0003);
    // ****************
    // reset in mid-run, then count pin one and the reload timers
    // ****************
    reload_run = 2'h0;
    reload_split = 2'h3;
    reload_value_a = 16'h7F80;
    reload_value_b = 16'hFFFE;
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk({timer0_high_byte, timer0_low_byte}, 16'h0000);
    chk({timer1_high_byte, timer1_low_byte}, 16'h0000);
    chk(reload_count_a | reload_count_b, 16'h0000);
    chk({10'h000, reload_flags, timer0_overflow_flag, timer1_overflow_flag}, 16'h0000);
    timer1_counter_mode = 1'b1;
    timer1_gate_bit = 1'b1;
    timer1_run_bit = 1'b1;
    u_fct_event_src.pulses(1'b1, 2);
    repeat (4) @(negedge clk);
    timer1_run_bit = 1'b0;
    chk({timer1_high_byte, timer1_low_byte}, 16'h0002);
    // both reload timers split for 256 ticks, then timer b whole for two more
    reload_run = 2'h3;
    repeat (256) @(negedge clk);
    reload_split = 2'h1;
    @(negedge clk);
    chk({12'h000, reload_flags}, 16'h000F);
    reload_flag_clr = 4'hF;
    @(negedge clk);
    reload_flag_clr = 4'h0;
    reload_run = 2'h0;
    @(negedge clk);
    chk({12'h000, reload_flags}, 16'h0008);
    chk(reload_count_a, 16'h8182);
    chk(reload_count_b, 16'hFFFE);
    give_verdict();
  end
endmodule // test_four_counter_timer_set
`default_nettype wire
